// >>> src/cxpl_defines.svh
// Functional notes
// R1 - Shift on clock when selected and serial
// R2 - Forty-bit chain, output after forty clocks
// R3 - Parallel write of addressed slot, clock low
// R4 - Parallel write forces reserved bit high
// R5 - Update low latches follow first rank; the code also needs chip select low and reset released
// R6 - Reset low disables all outputs immediately
// R7 - Reset clears only second rank
// R8 - Serial out shows shift register MSB
// R9 - Serial input sampled on falling clock
// R10 - Slot order: enable, reserved, select MSB-first
// R11 - Host sends highest output slot first
// R12 - Enable low disables output, ignores rest
// R13 - Decode slot to one-hot input select
`ifndef CXPL_DEFINES_SVH
`define CXPL_DEFINES_SVH
`define CXPL_NUM_OUT 8
`define CXPL_SLOT_W 5
`define CXPL_CHAIN_W 40
`define CXPL_SEL_W 3
`define CXPL_EN_POS 4
`define CXPL_RSV_POS 3
`define CXPL_SEL_MSB 2
`define CXPL_SYNC_W 2
`endif

// >>> src/cxpl_pkg.sv
package cxpl_pkg;
  typedef logic [4:0] cxpl_slot_t;
  typedef logic [7:0] cxpl_onehot_t;
endpackage

// >>> src/cxpl_dec_if.sv
`timescale 1ns/1ns
interface cxpl_dec_if;
  logic [39:0] rank2;
  logic [7:0] enables;
  logic [63:0] selects;
  modport src (output rank2, input enables, selects);
  modport dec (input rank2, output enables, selects);
endinterface

// >>> src/cxpl_decode.sv
`timescale 1ns/1ns
`include "cxpl_defines.svh"
module cxpl_decode (
  // Second rank in, decoded controls out
  cxpl_dec_if.dec dif
);
  function automatic cxpl_pkg::cxpl_onehot_t cxpl_dec_slot(
    input cxpl_pkg::cxpl_slot_t s);
    cxpl_pkg::cxpl_onehot_t oh;
    oh = 8'h00;
    if (s[`CXPL_EN_POS]) begin // [R12]
      oh[s[`CXPL_SEL_MSB:0]] = 1'b1; // [R13]
    end
    return oh;
  endfunction

  genvar g;
  generate
    for (g = 0; g < `CXPL_NUM_OUT; g++) begin : g_out
      assign dif.enables[g] =
        dif.rank2[g*`CXPL_SLOT_W+`CXPL_EN_POS]; // [R12]
      assign dif.selects[g*8+:8] =
        cxpl_dec_slot(dif.rank2[g*`CXPL_SLOT_W+:`CXPL_SLOT_W]); // [R13]
    end
  endgenerate
endmodule

// >>> src/cxpl_top.sv
`timescale 1ns/1ns
`include "cxpl_defines.svh"
module cxpl_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Host programming pins
  input wire logic prog_clk,
  input wire logic chip_sel_n,
  input wire logic update_n,
  input wire logic serial_parallel_select,
  input wire logic serial_data_in,
  input wire logic [3:0] parallel_slot_data,
  input wire logic [2:0] output_slot_address,
  // Serial chain out
  output logic serial_data_out,
  // Switch array controls
  output logic [7:0] output_enable,
  output logic [63:0] input_select
);
  // ==========================================
  // Reset release and pin sync
  // ==========================================
  logic [1:0] rst_sync_r;
  logic rst_n;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) rst_sync_r <= 2'h0;
    else rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // Pins are sampled without reset: first rank survives reset [R7]
  logic [9:0] meta_r, sync_r;
  always_ff @(posedge mclk) begin
    meta_r <= {prog_clk, chip_sel_n, update_n, serial_parallel_select,
      serial_data_in, parallel_slot_data, 1'b0};
    sync_r <= meta_r;
  end
  logic clk_s, cs_n_s, upd_n_s, par_s, sdi_s;
  logic [3:0] pd_s;
  assign {clk_s, cs_n_s, upd_n_s, par_s, sdi_s, pd_s} = sync_r[9:1];
  logic [2:0] adr_meta_r, adr_s;
  always_ff @(posedge mclk) begin
    adr_meta_r <= output_slot_address;
    adr_s <= adr_meta_r;
  end

  logic clk_d_r;
  always_ff @(posedge mclk) begin
    clk_d_r <= clk_s;
  end
  logic clk_fall;
  assign clk_fall = clk_d_r & ~clk_s; // [R9]

  // ==========================================
  // First rank
  // ==========================================
  logic [39:0] rank1_r, rank1_nxt;
  always_comb begin
    rank1_nxt = rank1_r;
    if (!cs_n_s) begin // [R1]
      if (!par_s && clk_fall) begin
        rank1_nxt = {rank1_r[38:0], sdi_s}; // [R1] [R2] [R10]
      end else if (par_s && !clk_s) begin
        rank1_nxt[adr_s*`CXPL_SLOT_W+:`CXPL_SLOT_W] =
          {pd_s[3], 1'b1, pd_s[2:0]}; // [R3] [R4]
      end
    end
  end
  always_ff @(posedge mclk) begin
    rank1_r <= rank1_nxt; // [R7]
  end

  always_ff @(posedge mclk) begin
    serial_data_out <= rank1_r[`CXPL_CHAIN_W-1]; // [R2] [R8]
  end

  // ==========================================
  // Second rank
  // ==========================================
  // Raw nrst here so reset clears the outputs without waiting a clock
  logic [39:0] rank2_r;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) rank2_r <= 40'h0; // [R6] [R7]
    else if (!upd_n_s && !cs_n_s && rst_n) rank2_r <= rank1_r; // [R5]
  end

  cxpl_dec_if dif ();
  assign dif.rank2 = rank2_r;
  cxpl_decode u_dec (
    .dif(dif)
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      output_enable <= 8'h00; // [R6]
      input_select <= 64'h0;
    end else begin
      output_enable <= dif.enables; // [R12]
      input_select <= dif.selects; // [R13]
    end
  end
endmodule

// >>> tb/cxpl_top_properties.sv
`timescale 1ns/1ns
module cxpl_chk (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic prog_clk,
  input wire logic chip_sel_n,
  input wire logic update_n,
  input wire logic serial_data_out,
  input wire logic [7:0] output_enable,
  input wire logic [63:0] input_select
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_rst_off: assert property (disable iff (1'b0) !nrst |->
    !output_enable && !input_select) else $error("rst");
  a_off_zero: assert property (!output_enable[0] |->
    !input_select[7:0]) else $error("off0");
  a_on_zero: assert property (output_enable[0] |->
    $onehot(input_select[7:0])) else $error("on0");
  a_off_top: assert property (!output_enable[7] |->
    !input_select[63:56]) else $error("off7");
  a_on_top: assert property (output_enable[7] |->
    $onehot(input_select[63:56])) else $error("on7");
  a_cs_hold: assert property (chip_sel_n [*8] |->
    $stable(output_enable) && $stable(serial_data_out)) else $error("cs");
  a_clk_hold: assert property (prog_clk [*8] |->
    $stable(serial_data_out)) else $error("clk");
  a_upd_hold: assert property (update_n [*8] |->
    $stable(input_select)) else $error("upd");
  cover property (output_enable == 8'hff);
  cover property (output_enable == 8'h7f);
  cover property (chip_sel_n [*8]);
endmodule
bind cxpl_top cxpl_chk chk (.mclk(mclk), .nrst(nrst), .prog_clk(prog_clk),
  .chip_sel_n(chip_sel_n), .update_n(update_n), .input_select(input_select),
  .serial_data_out(serial_data_out), .output_enable(output_enable));

// >>> tb/cxpl_host.sv
`timescale 1ns/1ns
module cxpl_host (
  output logic pclk,
  output logic sdi
);
  initial {pclk, sdi} = 2'b10;
  // Idle high so no stray falling edge
  task automatic low();
    #80 pclk = 0;
    #80 pclk = 1;
  endtask
  task automatic put(input logic [4:0] s);
    for (int i = 4; i >= 0; i--) begin
      sdi = s[i];
      #80 pclk = 0;
      // Spoil the bit once it is past its hold window
      #40 sdi = ~s[i];
      #40 pclk = 1;
    end
  endtask
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ns
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin err_count++; \
  $display("Error %s exp %h got %h", n, e, s); end end
module tb_top;
  logic mclk = 0, nrst = 1, cs_n = 0, upd_n = 1, sps = 0, pclk, sdi, sdo;
  logic [3:0] pd = 0;
  logic [2:0] pa = 0;
  logic [7:0] oe;
  logic [63:0] sel, e = 0;
  int err_count = 0, n_tests = 0, cyc = 0;
  always #5 mclk = ~mclk;
  cxpl_host host (.pclk(pclk), .sdi(sdi));
  cxpl_top dut (.mclk(mclk), .nrst(nrst), .prog_clk(pclk), .chip_sel_n(cs_n),
    .update_n(upd_n), .serial_parallel_select(sps), .serial_data_in(sdi),
    .parallel_slot_data(pd), .output_slot_address(pa),
    .serial_data_out(sdo), .output_enable(oe), .input_select(sel));
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic end_of_test();
    if (err_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge mclk) if (++cyc > 5000) begin
    err_count++;
    end_of_test();
  end
  task automatic t_serial();
    for (int g = 7; g >= 0; g--)
      host.put(g == 7 ? 5'h07 : {2'b11, 3'(g)});
    tick(8);
    `CHK("sdo", 1'b0, sdo)
    upd_n = 0;
    tick(10);
    for (int g = 0; g < 7; g++) e[9*g] = 1;
    `CHK("oe", 8'h7f, oe)
    `CHK("sel", e, sel)
  endtask
  task automatic t_par();
    {sps, pa, pd} = 8'hfd;
    host.low();
    tick(10);
    `CHK("sel7", 8'h20, sel[63:56])
    `CHK("sdo par", 1'b1, sdo)
  endtask
  task automatic t_rst();
    nrst = 0;
    #2;
    `CHK("oe rst", 8'h00, oe)
    tick(2);
    nrst = 1;
    tick(10);
    `CHK("oe kept", 8'hff, oe)
  endtask
  task automatic t_cs();
    {cs_n, pd} = 5'h10;
    host.low();
    tick(10);
    `CHK("oe cs", 8'hff, oe)
  endtask
  initial begin
    // A real falling edge, so the async clear is seen at 1 ns
    #1 nrst = 0;
    tick(10);
    nrst = 1;
    tick(3);
    t_serial();
    t_par();
    t_rst();
    t_cs();
    end_of_test();
  end
endmodule
